// ===== logic/afs_pkg.sv
/*
 * shared constants and carrier types of the axis fault supervisor:
 * register offsets, control field layout, reset values, timing counts.
 * assumes a 20 MHz core clock and current readings given in microamps.
 */
package afs_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int BLINK_CW = 23;
    typedef logic [BLINK_CW-1:0] afs_bcnt_type;

    // ------------------------------------------------------------------
    // signal widths and current-loop limits
    // ------------------------------------------------------------------
    localparam int LOOP_W = 16;
    localparam int SSI_W = 24;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int FLT_W = 6;
    localparam int CTRL_W = 9;
    localparam logic [LOOP_W-1:0] LOOP_MIN_UA = 16'h0e10; // 3.6 mA
    localparam logic [LOOP_W-1:0] LOOP_MAX_UA = 16'h5208; // 21.0 mA
    localparam logic [SSI_W-1:0] SSI_MAX_RST = 24'hffffff;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h1;
    localparam logic [ADDR_W-1:0] REG_ISTAT = 4'h2;
    localparam logic [ADDR_W-1:0] REG_IMASK = 4'h3;
    localparam logic [ADDR_W-1:0] REG_SSIMAX = 4'h4;

    // ------------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MON_OFF = 2'b00,
        MON_ON = 2'b01,
        MON_AUTO = 2'b10
    } afs_mon_type;

    typedef enum logic [1:0] {
        PM_WAIT = 2'b00,
        PM_OK = 2'b01,
        PM_ERR = 2'b10
    } afs_pm_type;

    // ------------------------------------------------------------------
    // register layouts (msb first)
    // ------------------------------------------------------------------
    typedef struct packed {
        logic save_cmd;
        logic pos_from_ssi;
        logic pos_range_420;
        logic press2_range_420;
        logic press1_range_420;
        logic loop_polarity_select;
        logic pressure_control_active;
        afs_mon_type sensor_monitor_select;
    } afs_ctrl_type;

    localparam afs_ctrl_type CTRL_RST = 9'h071;

    typedef struct packed {
        logic rc_lost;
        logic param_err;
        logic ssi;
        logic pos;
        logic press2;
        logic press1;
    } afs_flt_type;

    // ------------------------------------------------------------------
    // module state records
    // ------------------------------------------------------------------
    typedef struct packed {
        afs_pm_type pm;
        afs_ctrl_type ctrl;
        logic [SSI_W-1:0] ssi_max;
        afs_flt_type imask;
        afs_flt_type istat;
        logic rc_flt;
        logic out_en;
        logic ready;
        logic led;
        logic [LOOP_W-1:0] cmd;
        logic [DATA_W-1:0] rdata;
        logic save_pls;
        logic dflt_pls;
    } afs_sup_state_type;

    localparam afs_sup_state_type SUP_RST = '{pm: PM_WAIT, ctrl: CTRL_RST,
        ssi_max: SSI_MAX_RST, default: '0};

    typedef struct packed {
        afs_bcnt_type cnt;
        logic phase;
    } afs_blink_state_type;

    typedef struct packed {
        logic fault;
    } afs_loop_state_type;

endpackage : afs_pkg

// ===== logic/afs_loop_mon.sv
/*
 * range and broken-wire check for one current-loop feedback input.
 * assumes the reading is a microamp value synchronous to i_clk.
 */
`timescale 1ns/1ps
module afs_loop_mon (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // reading and setup
    input wire logic [afs_pkg::LOOP_W-1:0] i_value,
    input wire logic i_range_420,
    input wire logic i_mon_on,
    // result
    output logic o_fault
);

    afs_pkg::afs_loop_state_type st_ff;
    afs_pkg::afs_loop_state_type nxt_st;

    // ------------------------------------------------------------------
    // fault decision
    // ------------------------------------------------------------------
    // a low reading means a cut wire only when the live-zero range is set
    always_comb begin
        nxt_st = st_ff;
        nxt_st.fault = i_mon_on & ((i_value > afs_pkg::LOOP_MAX_UA) |
            (i_range_420 & (i_value < afs_pkg::LOOP_MIN_UA)));
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_fault = st_ff.fault;

endmodule : afs_loop_mon

// ===== logic/afs_blink.sv
/*
 * free-running flash phase for the ready indicator.
 * assumes a clock enable that freezes the count while low.
 */
`timescale 1ns/1ps
module afs_blink #(
    parameter int HALF_CYC = afs_pkg::BLINK_HALF_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // flash phase
    output logic o_phase
);

    localparam afs_pkg::afs_bcnt_type LAST = afs_pkg::afs_bcnt_type'(HALF_CYC - 1);

    afs_pkg::afs_blink_state_type st_ff;
    afs_pkg::afs_blink_state_type nxt_st;

    // ------------------------------------------------------------------
    // half-period counter
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (st_ff.cnt >= LAST) begin
            nxt_st.cnt = '0;
            nxt_st.phase = ~st_ff.phase;
        end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_phase = st_ff.phase;

endmodule : afs_blink

// ===== logic/afs_supervisor.sv
/*
 * axis fault supervisor: watches loop feedback, serial position sensor,
 * parameter memory check and the remote-control link, gates the valve
 * output, drives ready and its indicator, and serves a small register port.
 * assumes all inputs synchronous to i_clk and a 20 MHz clock.
 */
`timescale 1ns/1ps
module afs_supervisor #(
    parameter int BLINK_HALF_CYC = afs_pkg::BLINK_HALF_CYC
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // register port
    input wire logic [afs_pkg::ADDR_W-1:0] i_addr,
    input wire logic [afs_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [afs_pkg::DATA_W-1:0] o_rdata,
    // feedback inputs
    input wire logic [afs_pkg::LOOP_W-1:0] i_press1_ua,
    input wire logic [afs_pkg::LOOP_W-1:0] i_press2_ua,
    input wire logic [afs_pkg::LOOP_W-1:0] i_pos_ua,
    input wire logic [afs_pkg::SSI_W-1:0] i_ssi_pos,
    input wire logic i_ssi_err,
    // parameter memory check
    input wire logic i_pcheck_done,
    input wire logic i_pcheck_ok,
    // commissioning link and machine enable
    input wire logic i_remote_control_operation,
    input wire logic i_link_ok,
    input wire logic i_enable,
    // position loop output
    input wire logic [afs_pkg::LOOP_W-1:0] i_loop_out,
    // valve and status
    output logic o_valve_en,
    output logic [afs_pkg::LOOP_W-1:0] o_valve_cmd,
    output logic o_ready,
    output logic o_ready_led,
    output logic o_save_req,
    output logic o_load_defaults,
    output logic o_irq
);

    afs_pkg::afs_sup_state_type st_ff;
    afs_pkg::afs_sup_state_type nxt_st;

    logic mon_on;
    logic p1_flt;
    logic p2_flt;
    logic pos_flt;
    logic blink;
    logic ssi_flt;
    logic press_flt;
    logic rc_now;
    logic pm_bad;
    logic off_flt;
    logic any_flt;
    logic save_wr;
    afs_pkg::afs_flt_type flt;
    afs_pkg::afs_flt_type w1c;
    afs_pkg::afs_ctrl_type wctrl;
    logic [afs_pkg::DATA_W-1:0] rd_val;

    // ------------------------------------------------------------------
    // feedback monitors
    // ------------------------------------------------------------------
    assign mon_on = (st_ff.ctrl.sensor_monitor_select == afs_pkg::MON_ON) |
        (st_ff.ctrl.sensor_monitor_select == afs_pkg::MON_AUTO);

    afs_loop_mon u_press1 (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_value(i_press1_ua),
        .i_range_420(st_ff.ctrl.press1_range_420),
        .i_mon_on(mon_on),
        .o_fault(p1_flt)
    );

    afs_loop_mon u_press2 (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_value(i_press2_ua),
        .i_range_420(st_ff.ctrl.press2_range_420),
        .i_mon_on(mon_on),
        .o_fault(p2_flt)
    );

    // the loop input is not the feedback when the serial sensor is used
    afs_loop_mon u_pos (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_value(i_pos_ua),
        .i_range_420(st_ff.ctrl.pos_range_420),
        .i_mon_on(mon_on & ~st_ff.ctrl.pos_from_ssi),
        .o_fault(pos_flt)
    );

    afs_blink #(
        .HALF_CYC(BLINK_HALF_CYC)
    ) u_blink (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .o_phase(blink)
    );

    // ------------------------------------------------------------------
    // fault combination
    // ------------------------------------------------------------------
    // serial sensor: missing frame / error bit or value past the limit
    assign ssi_flt = mon_on & st_ff.ctrl.pos_from_ssi &
        (i_ssi_err | (i_ssi_pos > st_ff.ssi_max));
    // monitor flops lag a cycle; gate again so switching off acts at once
    assign press_flt = mon_on & (p1_flt | p2_flt);
    // live link loss counts at once, the latch holds it after return
    assign rc_now = mon_on & (st_ff.rc_flt |
        (i_remote_control_operation & ~i_link_ok));
    // waiting for the check also blocks, so no edge slips through early
    assign pm_bad = (st_ff.pm != afs_pkg::PM_OK);
    assign off_flt = (press_flt & st_ff.ctrl.pressure_control_active) |
        (mon_on & pos_flt) | ssi_flt | rc_now | pm_bad;
    assign flt = '{rc_lost: rc_now, param_err: (st_ff.pm == afs_pkg::PM_ERR), ssi: ssi_flt,
        pos: mon_on & pos_flt, press2: mon_on & p2_flt, press1: mon_on & p1_flt};
    assign any_flt = |flt;

    // ------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------
    assign wctrl = afs_pkg::afs_ctrl_type'(i_wdata[afs_pkg::CTRL_W-1:0]);
    assign save_wr = i_wr & (i_addr == afs_pkg::REG_CTRL) & wctrl.save_cmd;
    assign w1c = (i_wr & (i_addr == afs_pkg::REG_ISTAT)) ?
        afs_pkg::afs_flt_type'(i_wdata[afs_pkg::FLT_W-1:0]) : '0;

    // read mux; unmapped offsets read as zero
    always_comb begin
        rd_val = '0;
        case (i_addr)
            afs_pkg::REG_CTRL: begin
                rd_val[afs_pkg::CTRL_W-2:0] = st_ff.ctrl[afs_pkg::CTRL_W-2:0];
            end
            afs_pkg::REG_STAT: begin
                rd_val[afs_pkg::FLT_W-1:0] = flt;
                rd_val[afs_pkg::FLT_W] = st_ff.out_en;
                rd_val[afs_pkg::FLT_W+1] = st_ff.ready;
            end
            afs_pkg::REG_ISTAT: begin
                rd_val[afs_pkg::FLT_W-1:0] = st_ff.istat;
            end
            afs_pkg::REG_IMASK: begin
                rd_val[afs_pkg::FLT_W-1:0] = st_ff.imask;
            end
            afs_pkg::REG_SSIMAX: begin
                rd_val[afs_pkg::SSI_W-1:0] = st_ff.ssi_max;
            end
            default: begin
                rd_val = '0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.save_pls = save_wr;
        nxt_st.dflt_pls = 1'b0;
        nxt_st.rdata = i_rd ? rd_val : '0;
        // parameter memory check at power-up
        case (st_ff.pm)
            afs_pkg::PM_WAIT: begin
                if (i_pcheck_done) begin
                    nxt_st.pm = i_pcheck_ok ? afs_pkg::PM_OK : afs_pkg::PM_ERR;
                end
            end
            afs_pkg::PM_OK: begin
                nxt_st.pm = afs_pkg::PM_OK;
            end
            afs_pkg::PM_ERR: begin
                if (save_wr) begin
                    nxt_st.pm = afs_pkg::PM_OK;
                    nxt_st.dflt_pls = 1'b1;
                end
            end
            default: begin
                nxt_st.pm = afs_pkg::PM_WAIT;
            end
        endcase
        // register writes; the save bit itself is never stored
        if (i_wr && i_addr == afs_pkg::REG_CTRL) begin
            nxt_st.ctrl = wctrl;
            nxt_st.ctrl.save_cmd = 1'b0;
        end
        if (i_wr && i_addr == afs_pkg::REG_IMASK) begin
            nxt_st.imask = afs_pkg::afs_flt_type'(i_wdata[afs_pkg::FLT_W-1:0]);
        end
        if (i_wr && i_addr == afs_pkg::REG_SSIMAX) begin
            nxt_st.ssi_max = i_wdata[afs_pkg::SSI_W-1:0];
        end
        // default set replaces whatever was written alongside it
        if (nxt_st.dflt_pls) begin
            nxt_st.ctrl = afs_pkg::CTRL_RST;
            nxt_st.ssi_max = afs_pkg::SSI_MAX_RST;
        end
        // sticky status: a fault present in the clear cycle stays set
        nxt_st.istat = (st_ff.istat & ~w1c) | flt;
        // link-loss latch ends when remote control is left or monitoring is switched off
        nxt_st.rc_flt = rc_now & i_remote_control_operation;
        // output gating and ready
        nxt_st.out_en = i_enable & ~off_flt;
        nxt_st.ready = i_enable & ~off_flt;
        if (!nxt_st.out_en) begin
            nxt_st.cmd = '0;
        end else if (st_ff.ctrl.loop_polarity_select) begin
            nxt_st.cmd = afs_pkg::LOOP_W'(-i_loop_out);
        end else begin
            nxt_st.cmd = i_loop_out;
        end
        // indicator flashes on any fault while enabled, solid when ready
        nxt_st.led = (i_enable & any_flt) ? blink : nxt_st.ready;
    end

    // single state register, frozen while the clock enable is low
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= afs_pkg::SUP_RST;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_rdata = st_ff.rdata;
    assign o_valve_en = st_ff.out_en;
    assign o_valve_cmd = st_ff.cmd;
    assign o_ready = st_ff.ready;
    assign o_ready_led = st_ff.led;
    assign o_save_req = st_ff.save_pls;
    assign o_load_defaults = st_ff.dflt_pls;
    assign o_irq = |(st_ff.istat & st_ff.imask);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    mon_off_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !mon_on && i_enable && !pm_bad) |=> o_valve_en)
        else $error("output blocked with monitoring off");

    press_off_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && press_flt && st_ff.ctrl.pressure_control_active) |=> !o_valve_en)
        else $error("pressure fault did not disable output");

    press_ignore_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_enable && !st_ff.ctrl.pressure_control_active && !pos_flt &&
        !ssi_flt && !rc_now && !pm_bad) |=> o_valve_en)
        else $error("pressure fault acted in positioning mode");

    pos_off_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && (flt.pos || ssi_flt)) |=> (!o_valve_en && o_valve_cmd == '0))
        else $error("position fault did not switch output off");

    rc_off_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && mon_on && i_remote_control_operation && !i_link_ok)
        |=> (!o_valve_en && st_ff.rc_flt))
        else $error("link loss did not switch output off");

    pm_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_ff.pm != afs_pkg::PM_OK) |-> !o_valve_en)
        else $error("output active without good parameters");

    led_flash_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_enable && any_flt) |=> (o_ready_led == $past(blink)))
        else $error("indicator not flashing on fault");

    save_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && st_ff.pm == afs_pkg::PM_ERR && save_wr)
        |=> (st_ff.pm == afs_pkg::PM_OK && o_load_defaults && o_save_req &&
        st_ff.ctrl == afs_pkg::CTRL_RST))
        else $error("save did not clear parameter error");

    range_gate_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !st_ff.ctrl.press1_range_420 && i_press1_ua <= afs_pkg::LOOP_MAX_UA)
        |=> !p1_flt)
        else $error("wire break flagged outside live-zero range");

    polarity_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_enable && !off_flt && st_ff.ctrl.loop_polarity_select)
        |=> (o_valve_cmd == afs_pkg::LOOP_W'(-$past(i_loop_out))))
        else $error("polarity select did not invert output");

    ready_drop_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && off_flt) |=> (!o_ready &&
        (o_ready_led == ($past(i_enable) && $past(any_flt) && $past(blink)))))
        else $error("ready stayed high during disabling fault");

    sticky_set_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && |flt) |=> ((st_ff.istat & $past(flt)) == $past(flt)))
        else $error("status bit lost while its fault stood");

    irq_level_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !i_wr && |(flt & st_ff.imask)) |=> o_irq)
        else $error("unmasked fault did not raise interrupt");

    rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !i_rd) |=> (o_rdata == '0))
        else $error("read data stood without a read");

    cmd_zero_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !o_valve_en |-> (o_valve_cmd == '0))
        else $error("valve command left while output off");

    dflt_only_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && st_ff.pm != afs_pkg::PM_ERR) |=> !o_load_defaults)
        else $error("defaults loaded without parameter error");

    enable_off_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !i_enable) |=> (!o_valve_en && !o_ready))
        else $error("output or ready high without enable");

endmodule : afs_supervisor

// ===== dv/afs_far_model.sv
/*
 * far side of the axis fault supervisor: feedback sensors, parameter
 * memory check and the commissioning link, steered by a fault selector.
 * assumes the bench changes the selector just after a rising edge.
 */
`timescale 1ns/1ps
module afs_far_model (
    // clock
    input wire logic i_clk,
    // scenario selection: 0 none, 1 press1 wire, 2 pos wire, 3 sensor, 4 link
    input wire logic [2:0] i_fault_sel,
    input wire logic i_pcheck_good,
    // sensor and tool side
    output logic [afs_pkg::LOOP_W-1:0] o_press1_ua,
    output logic [afs_pkg::LOOP_W-1:0] o_press2_ua,
    output logic [afs_pkg::LOOP_W-1:0] o_pos_ua,
    output logic [afs_pkg::SSI_W-1:0] o_ssi_pos,
    output logic o_ssi_err,
    output logic o_pcheck_done,
    output logic o_pcheck_ok,
    output logic o_link_ok
);
    // a cut wire reads 0 uA; a live loop sits at 12 mA, mid range
    always_ff @(posedge i_clk) begin
        o_press1_ua <= (i_fault_sel == 3'h1) ? 16'h0000 : 16'h2ee0;
        o_press2_ua <= 16'h2ee0;
        o_pos_ua <= (i_fault_sel == 3'h2) ? 16'h0000 : 16'h2ee0;
        o_ssi_pos <= 24'h001000;
        o_ssi_err <= (i_fault_sel == 3'h3);
        o_pcheck_done <= 1'b1;
        o_pcheck_ok <= i_pcheck_good;
        o_link_ok <= (i_fault_sel != 3'h4);
    end
endmodule : afs_far_model

// ===== dv/test_axis_fault_supervisor.sv
/*
 * self-checking bench of the axis fault supervisor with its far-side model.
 * assumes a short flash period so the indicator can be seen toggling.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_axis_fault_supervisor;
    logic i_clk, i_rstn, i_wr, i_rd, i_rco, good, i_enable;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata, d;
    logic [2:0] sel;
    logic [15:0] p1, p2, pos, loop_out, o_valve_cmd;
    logic [23:0] ssi;
    logic serr, pdone, pok, link, o_valve_en, o_ready, o_ready_led, o_save_req, o_load_defaults, o_irq;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;

    afs_far_model i_far (.i_clk(i_clk), .i_fault_sel(sel), .i_pcheck_good(good), .o_press1_ua(p1),
        .o_press2_ua(p2), .o_pos_ua(pos), .o_ssi_pos(ssi), .o_ssi_err(serr), .o_pcheck_done(pdone),
        .o_pcheck_ok(pok), .o_link_ok(link));
    afs_supervisor #(.BLINK_HALF_CYC(4)) i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_press1_ua(p1), .i_press2_ua(p2), .i_pos_ua(pos), .i_ssi_pos(ssi), .i_ssi_err(serr),
        .i_pcheck_done(pdone), .i_pcheck_ok(pok), .i_remote_control_operation(i_rco), .i_link_ok(link),
        .i_enable(i_enable), .i_loop_out(loop_out), .o_valve_en(o_valve_en), .o_valve_cmd(o_valve_cmd),
        .o_ready(o_ready), .o_ready_led(o_ready_led), .o_save_req(o_save_req),
        .o_load_defaults(o_load_defaults), .o_irq(o_irq));

    // ----------------------------------------------------------------
    // clock, hang guard and bus tasks
    // ----------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // whole run is well under 1000 cycles; 5000 means a hang
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd

    task automatic fault(input logic [2:0] s);
        @(posedge i_clk);
        sel <= s;
        step(4);
    endtask : fault

    task automatic do_reset(input logic g);
        @(posedge i_clk);
        good <= g;
        i_rstn <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        step(4);
    endtask : do_reset

    // indicator must show both levels within three half periods
    task automatic blink();
        logic [1:0] saw;
        saw = 2'b00;
        repeat (12) begin
            step(1);
            saw[o_ready_led] = 1'b1;
        end
        `CHK(saw, 2'b11)
    endtask : blink

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd(afs_pkg::REG_CTRL);
        `CHK(d, 32'h0000_0071)
        rd(4'hf);
        `CHK(d, 32'h0000_0000)
        `CHK({o_valve_en, o_ready, o_ready_led, o_valve_cmd}, {3'b111, 16'h0100})
        $display("test regs done");
    endtask : t_regs

    task automatic t_param();
        do_reset(1'b0);
        `CHK({o_valve_en, o_ready}, 2'b00)
        rd(afs_pkg::REG_STAT);
        `CHK(d[4], 1'b1)
        blink();
        wr(afs_pkg::REG_CTRL, 32'h0000_0079);
        wr(afs_pkg::REG_CTRL, 32'h0000_0100);
        `CHK({o_save_req, o_load_defaults}, 2'b11)
        step(3);
        `CHK(o_valve_en, 1'b1)
        rd(afs_pkg::REG_CTRL);
        `CHK(d, 32'h0000_0071)
        $display("test param done");
    endtask : t_param

    task automatic t_press();
        wr(afs_pkg::REG_IMASK, 32'h0000_003f);
        fault(3'h1);
        `CHK(o_valve_en, 1'b1)
        wr(afs_pkg::REG_CTRL, 32'h0000_0075);
        step(3);
        `CHK({o_valve_en, o_ready, o_irq}, 3'b001)
        blink();
        fault(3'h0);
        wr(afs_pkg::REG_CTRL, 32'h0000_0071);
        wr(afs_pkg::REG_ISTAT, 32'h0000_003f);
        step(2);
        `CHK(o_irq, 1'b0)
        $display("test press done");
    endtask : t_press

    task automatic t_pos();
        wr(afs_pkg::REG_IMASK, 32'h0000_0000);
        fault(3'h2);
        `CHK({o_valve_en, o_ready, o_irq}, 3'b000)
        wr(afs_pkg::REG_IMASK, 32'h0000_003f);
        step(2);
        `CHK(o_irq, 1'b1)
        fault(3'h0);
        wr(afs_pkg::REG_ISTAT, 32'h0000_003f);
        step(2);
        `CHK(o_irq, 1'b0)
        wr(afs_pkg::REG_CTRL, 32'h0000_0031);
        fault(3'h2);
        `CHK(o_valve_en, 1'b1)
        wr(afs_pkg::REG_CTRL, 32'h0000_0070);
        step(3);
        `CHK(o_valve_en, 1'b1)
        wr(afs_pkg::REG_CTRL, 32'h0000_0072);
        step(3);
        `CHK(o_valve_en, 1'b0)
        fault(3'h0);
        wr(afs_pkg::REG_CTRL, 32'h0000_00f1);
        fault(3'h3);
        `CHK(o_valve_en, 1'b0)
        fault(3'h0);
        `CHK(o_valve_en, 1'b1)
        wr(afs_pkg::REG_SSIMAX, 32'h0000_0fff);
        step(2);
        `CHK(o_valve_en, 1'b0)
        rd(afs_pkg::REG_SSIMAX);
        `CHK(d, 32'h0000_0fff)
        $display("test pos done");
    endtask : t_pos

    task automatic t_link();
        wr(afs_pkg::REG_CTRL, 32'h0000_0071);
        @(posedge i_clk);
        i_rco <= 1'b1;
        fault(3'h4);
        `CHK(o_valve_en, 1'b0)
        fault(3'h0);
        `CHK(o_valve_en, 1'b0)
        @(posedge i_clk);
        i_rco <= 1'b0;
        step(3);
        `CHK(o_valve_en, 1'b1)
        wr(afs_pkg::REG_CTRL, 32'h0000_0079);
        step(2);
        `CHK(o_valve_cmd, 16'hff00)
        wr(afs_pkg::REG_CTRL, 32'h0000_0071);
        step(2);
        `CHK(o_valve_cmd, 16'h0100)
        $display("test link done");
    endtask : t_link

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        {i_rstn, i_wr, i_rd, i_rco, good} = 5'b00000;
        i_enable = 1'b1;
        i_addr = 4'h0;
        i_wdata = 32'h0;
        sel = 3'h0;
        loop_out = 16'h0100;
        do_reset(1'b1);
        t_regs();
        t_param();
        t_press();
        t_pos();
        t_link();
        final_report();
    end
endmodule : test_axis_fault_supervisor
